// >>> verilog/dsp_slice_pkg.sv
package dsp_slice_pkg;

    // ==========================================================
    // Bus map and bus encodings
    // ==========================================================
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;
    localparam logic [7:0] ACC_OFS = 8'h0c;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================================
    // Configuration and status word layout
    // ==========================================================
    localparam int CFG_W = 25;
    localparam logic [CFG_W-1:0] CFG_RESET = 25'h0000000;
    localparam int STATUS_ILLEGAL_BIT = 0;
    localparam int STATUS_UPPER_CARRY_BIT = 1;
    localparam int STATUS_LOWER_CARRY_BIT = 2;

    // ==========================================================
    // Select encodings
    // ==========================================================
    localparam logic [1:0] OUT_SEL_SUM = 2'h0;
    localparam logic [1:0] OUT_SEL_ACC = 2'h1;
    localparam logic [1:0] OUT_SEL_SMALL = 2'h2;
    localparam logic [1:0] OUT_SEL_WIDE = 2'h3;
    localparam logic [1:0] LO_SEL_DIRECT = 2'h0;
    localparam logic [1:0] LO_SEL_SMALL = 2'h1;
    localparam logic [1:0] LO_SEL_WIDE = 2'h2;
    localparam logic [1:0] LO_SEL_SIGN = 2'h3;
    localparam logic [1:0] CARRY_SEL_ZERO = 2'h0;
    localparam logic [1:0] CARRY_SEL_ONE = 2'h1;
    localparam logic [1:0] CARRY_SEL_CASCADE = 2'h2;
    localparam logic [1:0] CARRY_SEL_TILE = 2'h3;

    // Static options, bit 0 first from the bottom
    typedef struct packed {
        logic b_signed;
        logic a_signed;
        logic split_multiplier_mode;
        logic [1:0] lower_adder_carry_sel;
        logic lower_adder_operand_hi_sel;
        logic [1:0] lower_adder_operand_lo_sel;
        logic [1:0] lower_out_sel;
        logic [1:0] upper_adder_carry_sel;
        logic upper_adder_operand_hi_sel;
        logic [1:0] upper_adder_operand_lo_sel;
        logic [1:0] upper_out_sel;
        logic wide_product_stage2_reg;
        logic wide_product_stage1_reg;
        logic lower_small_product_reg;
        logic upper_small_product_reg;
        logic d_reg;
        logic c_reg;
        logic b_reg;
        logic a_reg;
    } cfg_t;

    // Operand bundle from the fabric
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
        logic [15:0] d;
    } operands_t;

    // Control strobes from the fabric, all active high
    typedef struct packed {
        logic operand_a_freeze;
        logic operand_b_freeze;
        logic operand_c_freeze;
        logic operand_d_freeze;
        logic upper_input_clear;
        logic lower_input_clear;
        logic acc_high_clear;
        logic acc_low_clear;
        logic acc_high_load_sel;
        logic acc_low_load_sel;
        logic upper_subtract_sel;
        logic lower_subtract_sel;
        logic acc_high_freeze;
        logic acc_low_freeze;
    } controls_t;

    // Cascade chain between neighbouring slices
    typedef struct packed {
        logic carry;
        logic sign;
    } cascade_t;

endpackage : dsp_slice_pkg

// >>> verilog/dsp_slice.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module dsp_slice #(
    parameter bit CLOCK_POLARITY_SEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic ce,
    input wire dsp_slice_pkg::operands_t operands,
    input wire dsp_slice_pkg::controls_t controls,
    input wire logic tile_carry_in,
    input wire dsp_slice_pkg::cascade_t cascade_in,
    output logic [31:0] result_out,
    output logic tile_carry_out,
    output dsp_slice_pkg::cascade_t cascade_out
);
    import dsp_slice_pkg::*;

    // ==========================================================
    // Functions
    // ==========================================================
    // 8x8 multiply with per-operand signedness
    function automatic logic [15:0] mul8(input logic [7:0] x, input logic [7:0] y,
                                         input logic xs, input logic ys);
        logic signed [8:0] sx;
        logic signed [8:0] sy;
        logic signed [17:0] p;
        sx = {xs & x[7], x};
        sy = {ys & y[7], y};
        p = sx * sy;
        return p[15:0];
    endfunction : mul8

    // 16x16 multiply with per-operand signedness
    function automatic logic [31:0] mul16(input logic [15:0] x, input logic [15:0] y,
                                          input logic xs, input logic ys);
        logic signed [16:0] sx;
        logic signed [16:0] sy;
        logic signed [33:0] p;
        sx = {xs & x[15], x};
        sy = {ys & y[15], y};
        p = sx * sy;
        return p[31:0];
    endfunction : mul16

    // 16-bit add or subtract; bit 16 is carry, or borrow when subtracting
    function automatic logic [16:0] addsub(input logic [15:0] w, input logic [15:0] x,
                                           input logic cin, input logic sub);
        logic [16:0] r;
        if (sub) begin
            r = {1'b0, w} - {1'b0, x} - {16'h0000, cin};
        end else begin
            r = {1'b0, w} + {1'b0, x} + {16'h0000, cin};
        end
        return r;
    endfunction : addsub

    // Carry selection for the lower adder; the upper adder decodes its own carry from lower_sum[16]
    function automatic logic pick_carry(input logic [1:0] sel, input logic c2, input logic c3);
        logic r;
        case (sel)
            CARRY_SEL_ZERO: r = 1'b0;
            CARRY_SEL_ONE: r = 1'b1;
            CARRY_SEL_CASCADE: r = c2;
            default: r = c3;
        endcase
        return r;
    endfunction : pick_carry

    // ==========================================================
    // Clock edge choice
    // ==========================================================
    logic slice_clk;
    assign slice_clk = clk ^ CLOCK_POLARITY_SEL;

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    cfg_t cfg_ff;
    logic wr_pend_ff;
    logic [7:0] wr_off_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] acc_ff;
    logic [16:0] upper_sum;
    logic [16:0] lower_sum;
    logic illegal_cfg;
    logic addr_phase;
    logic addr_in_map;
    logic cfg_fwd;
    logic [31:0] rd_word;

    // Address decode; only whole-word accesses inside the low page count
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign addr_in_map = (haddr[31:8] == 24'h000000);
    assign cfg_fwd = wr_pend_ff && (wr_off_ff == CFG_OFS) && (haddr[7:0] == CFG_OFS);
    assign illegal_cfg = cfg_ff.split_multiplier_mode
        && (cfg_ff.wide_product_stage1_reg || cfg_ff.wide_product_stage2_reg);

    // Read mux; a read straight after a config write sees the new word
    always_comb begin
        rd_word = 32'h00000000;
        if (addr_in_map) begin
            case (haddr[7:0])
                CFG_OFS: rd_word = cfg_fwd ? {7'h00, hwdata[CFG_W-1:0]} : {7'h00, cfg_ff};
                STATUS_OFS: rd_word = {29'h00000000, lower_sum[16], upper_sum[16], illegal_cfg};
                RESULT_OFS: rd_word = result_out;
                ACC_OFS: rd_word = acc_ff;
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    // Address phase capture and zero-wait answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_off_ff <= 8'h00;
            hrdata_ff <= 32'h00000000;
            hreadyout_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff <= addr_phase && hwrite && addr_in_map;
            wr_off_ff <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                hrdata_ff <= rd_word;
            end
        end
    end

    // Configuration register written in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_RESET;
        end else if (wr_pend_ff && (wr_off_ff == CFG_OFS)) begin
            cfg_ff <= hwdata[CFG_W-1:0];
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = 1'b0;

    // ==========================================================
    // Operand registers
    // ==========================================================
    logic [15:0] a_ff;
    logic [15:0] b_ff;
    logic [15:0] c_ff;
    logic [15:0] d_ff;
    logic [15:0] a_in;
    logic [15:0] b_in;
    logic [15:0] c_in;
    logic [15:0] d_in;

    // Clears win over freeze; C is cleared by either input clear
    always_ff @(posedge slice_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_ff <= 16'h0000;
            b_ff <= 16'h0000;
            c_ff <= 16'h0000;
            d_ff <= 16'h0000;
        end else if (ce) begin
            if (controls.upper_input_clear) a_ff <= 16'h0000;
            else if (!controls.operand_a_freeze) a_ff <= operands.a;
            if (controls.lower_input_clear) b_ff <= 16'h0000;
            else if (!controls.operand_b_freeze) b_ff <= operands.b;
            if (controls.upper_input_clear || controls.lower_input_clear) c_ff <= 16'h0000;
            else if (!controls.operand_c_freeze) c_ff <= operands.c;
            if (!controls.operand_d_freeze) d_ff <= operands.d;
        end
    end

    // Registered or raw operand choice
    assign a_in = cfg_ff.a_reg ? a_ff : operands.a;
    assign b_in = cfg_ff.b_reg ? b_ff : operands.b;
    assign c_in = cfg_ff.c_reg ? c_ff : operands.c;
    assign d_in = cfg_ff.d_reg ? d_ff : operands.d;

    // ==========================================================
    // Multipliers and product pipeline
    // ==========================================================
    logic [15:0] top8_raw;
    logic [15:0] bot8_raw;
    logic [31:0] wide_raw;
    logic [15:0] top8_ff;
    logic [15:0] bot8_ff;
    logic [31:0] stage1_ff;
    logic [31:0] stage2_ff;
    logic [15:0] top8;
    logic [15:0] bot8;
    logic [31:0] wide_s1;
    logic [31:0] wide;
    logic split;

    // Split mode: both bytes pairs multiply independently with their own sign
    assign split = cfg_ff.split_multiplier_mode;
    assign top8_raw = mul8(a_in[15:8], b_in[15:8], cfg_ff.a_signed, cfg_ff.b_signed);
    assign bot8_raw = mul8(a_in[7:0], b_in[7:0], cfg_ff.a_signed & split, cfg_ff.b_signed & split);
    assign wide_raw = split ? {top8_raw, bot8_raw}
                            : mul16(a_in, b_in, cfg_ff.a_signed, cfg_ff.b_signed);

    // Product registers with their upper and lower clears
    always_ff @(posedge slice_clk or negedge rst_n) begin
        if (!rst_n) begin
            top8_ff <= 16'h0000;
            bot8_ff <= 16'h0000;
            stage1_ff <= 32'h00000000;
            stage2_ff <= 32'h00000000;
        end else if (ce) begin
            top8_ff <= controls.upper_input_clear ? 16'h0000 : top8_raw;
            bot8_ff <= controls.lower_input_clear ? 16'h0000 : bot8_raw;
            stage1_ff[31:16] <= controls.upper_input_clear ? 16'h0000 : wide_raw[31:16];
            stage1_ff[15:0] <= controls.lower_input_clear ? 16'h0000 : wide_raw[15:0];
            stage2_ff <= controls.lower_input_clear ? 32'h00000000 : wide_s1;
        end
    end

    // Optional register insertion; 16x16 stages are bypassed in split mode
    assign top8 = cfg_ff.upper_small_product_reg ? top8_ff : top8_raw;
    assign bot8 = cfg_ff.lower_small_product_reg ? bot8_ff : bot8_raw;
    assign wide_s1 = (cfg_ff.wide_product_stage1_reg && !split) ? stage1_ff : wide_raw;
    assign wide = (cfg_ff.wide_product_stage2_reg && !split) ? stage2_ff : wide_s1;

    // ==========================================================
    // Adder/subtractors
    // ==========================================================
    logic [15:0] lower_w;
    logic [15:0] lower_x;
    logic lower_carry_term;
    logic [15:0] upper_w;
    logic [15:0] upper_x;
    logic upper_carry_term;

    // Lower unit operands; cascade inputs trusted to come from the slice below
    assign lower_w = cfg_ff.lower_adder_operand_hi_sel ? c_in : acc_ff[15:0];
    always_comb begin
        case (cfg_ff.lower_adder_operand_lo_sel)
            LO_SEL_DIRECT: lower_x = b_in;
            LO_SEL_SMALL: lower_x = bot8;
            LO_SEL_WIDE: lower_x = wide[15:0];
            default: lower_x = {16{cascade_in.sign}};
        endcase
    end
    assign lower_carry_term = pick_carry(cfg_ff.lower_adder_carry_sel,
                                         cascade_in.carry, tile_carry_in);
    assign lower_sum = addsub(lower_w, lower_x, lower_carry_term, controls.lower_subtract_sel);

    // Upper unit operands, chained to the lower unit
    assign upper_w = cfg_ff.upper_adder_operand_hi_sel ? c_in : acc_ff[31:16];
    always_comb begin
        case (cfg_ff.upper_adder_operand_lo_sel)
            LO_SEL_DIRECT: upper_x = a_in;
            LO_SEL_SMALL: upper_x = top8;
            LO_SEL_WIDE: upper_x = wide[31:16];
            default: upper_x = {16{lower_sum[15]}};
        endcase
    end
    assign upper_carry_term = (cfg_ff.upper_adder_carry_sel == CARRY_SEL_ZERO) ? 1'b0 :
                              (cfg_ff.upper_adder_carry_sel == CARRY_SEL_ONE) ? 1'b1 : lower_sum[16];
    assign upper_sum = addsub(upper_w, upper_x, upper_carry_term, controls.upper_subtract_sel);

    // ==========================================================
    // Accumulator
    // ==========================================================
    // Per-half clear, freeze and load select; clear wins over freeze
    always_ff @(posedge slice_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 32'h00000000;
        end else if (ce) begin
            if (controls.acc_high_clear) acc_ff[31:16] <= 16'h0000;
            else if (!controls.acc_high_freeze)
                acc_ff[31:16] <= controls.acc_high_load_sel ? c_in : upper_sum[15:0];
            if (controls.acc_low_clear) acc_ff[15:0] <= 16'h0000;
            else if (!controls.acc_low_freeze)
                acc_ff[15:0] <= controls.acc_low_load_sel ? d_in : lower_sum[15:0];
        end
    end

    // ==========================================================
    // Output selection and chain outputs
    // ==========================================================
    always_comb begin
        case (cfg_ff.upper_out_sel)
            OUT_SEL_SUM: result_out[31:16] = upper_sum[15:0];
            OUT_SEL_ACC: result_out[31:16] = acc_ff[31:16];
            OUT_SEL_SMALL: result_out[31:16] = top8;
            default: result_out[31:16] = wide[31:16];
        endcase
        case (cfg_ff.lower_out_sel)
            OUT_SEL_SUM: result_out[15:0] = lower_sum[15:0];
            OUT_SEL_ACC: result_out[15:0] = acc_ff[15:0];
            OUT_SEL_SMALL: result_out[15:0] = bot8;
            default: result_out[15:0] = wide[15:0];
        endcase
    end
    assign tile_carry_out = upper_sum[16];
    assign cascade_out = '{carry: upper_sum[16], sign: upper_sum[15]};

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_ce_gates;
        @(posedge slice_clk) disable iff (!rst_n) !ce |=> $stable(acc_ff) && $stable(a_ff) && $stable(stage2_ff);
    endproperty
    a_ce_gates: assert property (p_ce_gates) else $error("state moved while ce low");

    property p_a_load;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && !controls.operand_a_freeze && !controls.upper_input_clear |=> a_ff == $past(operands.a);
    endproperty
    a_a_load: assert property (p_a_load) else $error("operand A did not load");

    property p_d_hold;
        @(posedge slice_clk) disable iff (!rst_n) ce && controls.operand_d_freeze |=> $stable(d_ff);
    endproperty
    a_d_hold: assert property (p_d_hold) else $error("operand D moved while frozen");

    property p_upper_clear;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && controls.upper_input_clear |=> a_ff == 16'h0000 && c_ff == 16'h0000 && top8_ff == 16'h0000;
    endproperty
    a_upper_clear: assert property (p_upper_clear) else $error("upper clear incomplete");

    property p_lower_clear;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && controls.lower_input_clear |=> b_ff == 16'h0000 && stage2_ff == 32'h00000000;
    endproperty
    a_lower_clear: assert property (p_lower_clear) else $error("lower clear incomplete");

    property p_acc_high_clear;
        @(posedge slice_clk) disable iff (!rst_n) ce && controls.acc_high_clear |=> acc_ff[31:16] == 16'h0000;
    endproperty
    a_acc_high_clear: assert property (p_acc_high_clear) else $error("high accumulator not cleared");

    property p_acc_high_load;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && !controls.acc_high_clear && !controls.acc_high_freeze && controls.acc_high_load_sel
            |=> acc_ff[31:16] == $past(c_in);
    endproperty
    a_acc_high_load: assert property (p_acc_high_load) else $error("high accumulator missed C load");

    property p_acc_low_freeze;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && controls.acc_low_freeze && !controls.acc_low_clear |=> $stable(acc_ff[15:0]);
    endproperty
    a_acc_low_freeze: assert property (p_acc_low_freeze) else $error("low accumulator moved while frozen");

    property p_accumulate;
        @(posedge slice_clk) disable iff (!rst_n)
            ce && !controls.acc_low_clear && !controls.acc_low_freeze && !controls.acc_low_load_sel
            && !cfg_ff.lower_adder_operand_hi_sel && !controls.lower_subtract_sel
            |=> acc_ff[15:0] == 16'($past(acc_ff[15:0]) + $past(lower_x) + {15'h0000, $past(lower_carry_term)});
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("low accumulate sum wrong");

    property p_upper_out_acc;
        @(posedge slice_clk) disable iff (!rst_n)
            cfg_ff.upper_out_sel == OUT_SEL_ACC |-> result_out[31:16] == acc_ff[31:16];
    endproperty
    a_upper_out_acc: assert property (p_upper_out_acc) else $error("upper output not accumulator");

    property p_split_bypass;
        @(posedge slice_clk) disable iff (!rst_n)
            split && cfg_ff.lower_out_sel == OUT_SEL_WIDE |-> result_out[15:0] == bot8_raw;
    endproperty
    a_split_bypass: assert property (p_split_bypass) else $error("split mode used wide pipeline");

    c_split: cover property (@(posedge slice_clk) disable iff (!rst_n) split && ce);
    c_subtract: cover property (@(posedge slice_clk) disable iff (!rst_n) ce && controls.upper_subtract_sel);
    c_cascade: cover property (@(posedge slice_clk) disable iff (!rst_n)
        cfg_ff.lower_adder_carry_sel == CARRY_SEL_CASCADE && cascade_in.carry);
    c_bus_read: cover property (@(posedge clk) disable iff (!rst_n) addr_phase && !hwrite);

endmodule : dsp_slice

// >>> verif/prev_slice_model.sv
`timescale 1ns/100ps
// ==========
// Preceding slice stand-in driving the cascade chain
module prev_slice_model (
    input wire logic carry,
    input wire logic sign,
    output dsp_slice_pkg::cascade_t chain
);
    import dsp_slice_pkg::*;
    // Only this neighbour feeds the cascade inputs
    assign chain = '{carry: carry, sign: sign};
endmodule : prev_slice_model

// >>> verif/dsp_multiply_accumulate_slice_tb_top.sv
`timescale 1ns/100ps
// ==========
// Slice bench
module dsp_multiply_accumulate_slice_tb_top;
    import dsp_slice_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, ce = 1'b0, tci = 1'b0, cc = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0, rd, hrdata, res, res_neg;
    logic [31:0] sel_exp [4] = '{32'h03040506, 32'h000f0018, 32'h000f2618, 32'hffffffff};
    logic tco;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    logic hreadyout, hresp;
    operands_t ops = '0;
    controls_t ctl = '0;
    cascade_t cin, cout;
    int mismatches = 0, checks_done = 0;
    // Clock
    always #25 clk = ~clk;
    prev_slice_model u_prev (.carry(cc), .sign(1'b1), .chain(cin));
    dsp_slice u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .ce(ce), .operands(ops), .controls(ctl), .tile_carry_in(tci),
        .cascade_in(cin), .result_out(res), .tile_carry_out(tco), .cascade_out(cout));
    // Falling-edge copy on the same bus and fabric inputs
    dsp_slice #(.CLOCK_POLARITY_SEL(1'b1)) u_dut_neg (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(),
        .hrdata(), .hresp(), .ce(ce), .operands(ops), .controls(ctl), .tile_carry_in(tci),
        .cascade_in(cin), .result_out(res_neg), .tile_carry_out(), .cascade_out());
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : cmp
    // One bus transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic dp(input string n, input logic [31:0] e);
        #1;
        cmp(n, e, res);
        cmp(n, e, res_neg);
        @(posedge clk);
    endtask : dp
    // Clock enable high for exactly one edge
    task automatic pulse;
        ce <= 1'b1;
        @(posedge clk);
        ce <= 1'b0;
    endtask : pulse
    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ops <= '{a: 16'h3, b: 16'h5, c: 16'h7, d: 16'h0};
        bus(1'b0, CFG_OFS, '0);
        cmp("cfg", {7'h0, CFG_RESET}, rd);
        cmp("hresp", 32'h00000000, {31'h0, hresp});
        bus(1'b0, 8'h10, '0);
        cmp("unmapped", '0, rd);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CFG_OFS, 32'(i) << 20);
            dp("carry", {16'h3, 16'h5 + 16'(i == 1 || i == 2)});
        end
        bus(1'b1, CFG_OFS, '0);
        // One enabled cycle: the falling-edge copy moves half a clock earlier
        ce <= 1'b1;
        @(negedge clk);
        #1;
        cmp("falling edge", 32'h0006000a, res_neg);
        cmp("rising edge", 32'h00030005, res);
        @(posedge clk);
        ce <= 1'b0;
        dp("acc", {16'h6, 16'ha});
        ctl.acc_high_freeze <= 1'b1;
        pulse;
        dp("freeze", {16'h6, 16'hf});
        ctl.upper_subtract_sel <= 1'b1;
        dp("sub", {16'h0, 16'hf});
        ctl <= '{acc_high_load_sel: 1'b1, acc_low_clear: 1'b1, default: 1'b0};
        pulse;
        dp("load", {16'ha, 16'h5});
        ctl <= '0;
        repeat (2) @(posedge clk);
        dp("gate", {16'ha, 16'h5});
        bus(1'b1, CFG_OFS, 32'h00008100);
        dp("acc out", 32'h00070000);
        bus(1'b0, RESULT_OFS, '0);
        cmp("result reg", 32'h00070000, rd);
        bus(1'b0, ACC_OFS, '0);
        cmp("acc reg", 32'h00070000, rd);
        ops <= '{a: 16'hffff, b: 16'h2, c: 16'h0, d: 16'h0};
        bus(1'b1, CFG_OFS, 32'h00018300);
        dp("umul", 32'h0001fffe);
        bus(1'b1, CFG_OFS, 32'h01818300);
        dp("smul", 32'hfffffffe);
        ops <= '{a: 16'h0304, b: 16'h0506, c: 16'h0, d: 16'h0};
        bus(1'b1, CFG_OFS, 32'h00410200);
        dp("split", 32'h000f0018);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CFG_OFS, 32'h00081000 | (32'(i) << 17) | (32'(i) << 10));
            dp("operand sel", sel_exp[i]);
        end
        bus(1'b1, CFG_OFS, 32'h00418340);
        dp("split wide", 32'h000f0018);
        bus(1'b0, STATUS_OFS, '0);
        cmp("illegal", 32'h00000001, rd);
        // Registered operands feeding registered small products
        bus(1'b1, CFG_OFS, 32'h00010233);
        dp("pipe0", 32'h0000000f);
        pulse;
        dp("pipe1", 32'h0000000f);
        pulse;
        dp("pipe2", 32'h000f0018);
        ops.a <= 16'h0704;
        ctl <= '{operand_a_freeze: 1'b1, operand_d_freeze: 1'b1, acc_low_freeze: 1'b1, default: 1'b0};
        pulse;
        dp("a hold", 32'h000f0018);
        pulse;
        dp("a freeze", 32'h000f0018);
        ctl <= '{upper_input_clear: 1'b1, default: 1'b0};
        pulse;
        dp("upper clear", 32'h00000018);
        ctl <= '{lower_input_clear: 1'b1, default: 1'b0};
        pulse;
        dp("lower clear", 32'h00000000);
        // Carry chained from the lower unit, seen on the chain outputs
        ctl <= '0;
        ops <= '{a: 16'hffff, b: 16'hffff, c: 16'h0, d: 16'h0};
        for (int i = 2; i < 4; i++) begin
            bus(1'b1, CFG_OFS, 32'h00181000 | (32'(i) << 13));
            dp("upper carry", 32'h00000000);
            cmp("chain", 32'h00000006, {29'h0, tco, cout});
        end
        bus(1'b0, STATUS_OFS, '0);
        cmp("carries", 32'h00000006, rd);
        ops.a <= 16'h7fff;
        dp("sign", 32'h80000000);
        cmp("chain sign", 32'h00000001, {29'h0, tco, cout});
        wrap_up;
    end
endmodule : dsp_multiply_accumulate_slice_tb_top
